// ### src/flash_erase_pkg.sv
// Purpose: Shared constants and types for the flash row erase controller.
// Assumes: 32-bit AXI4-Lite register bus, 250 MHz clock.
// Notes:   Register offsets are byte addresses, one aligned word each.
package flash_erase_pkg;

  localparam logic [7:0] OFS_DATA_LOW   = 8'h00;
  localparam logic [7:0] OFS_DATA_HIGH  = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW   = 8'h08;
  localparam logic [7:0] OFS_ADDR_HIGH  = 8'h0c;
  localparam logic [7:0] OFS_CONTROL    = 8'h10;
  localparam logic [7:0] OFS_UNLOCK     = 8'h14;

  // Control register bit positions, then the address high top bit
  localparam int BIT_START      = 0;
  localparam int BIT_PROGRAM_WRITE_ENABLE       = 2;
  localparam int BIT_REFUSED    = 3;
  localparam int BIT_ERASE_SEL  = 4;
  localparam int BIT_CFG_SEL    = 6;
  localparam int ADDR_HIGH_TOP  = 7;

  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam int CLK_MHZ         = 250;
  localparam int SETUP_CYCLES    = 2;
  localparam int ERASE_TIME_NS   = 2000000;
  localparam int ERASE_CYCLES    = ERASE_TIME_NS / 1000 * CLK_MHZ;
  localparam int ROW_WORDS_LOG2  = 5;
  localparam int RESUME_OFFSET   = 3;
  localparam int ADDR_W          = 15;
  localparam int COUNT_W         = 24;

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ERASE} phase_t;
  typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_OPEN} unlock_t;

  typedef struct packed {
    logic              erase_on;
    logic              config_space;
    logic [ADDR_W-1:0] row_addr;
  } flash_cmd_t;

  typedef struct packed {
    logic              resume;
    logic [ADDR_W-1:0] resume_pc;
  } core_resume_t;

endpackage : flash_erase_pkg

// ### src/flash_row_erase_control.sv
// Purpose: Row erase sequencer for on-chip flash with an AXI4-Lite register file.
// Assumes: The core stops executing while cpu_stall is high; cpu_pc is the
//          address of the instruction that performs the control register write.
// Notes:   Clocks are never gated here, so peripherals keep running during an erase.
`timescale 1ns/1ps

// Functional notes
// - Program memory is erased only as whole rows, never single words.
// - Any address inside a row selects that whole row for erase.
// - Unlock port must receive 55h then AAh before an erase can start.
// - After unlocking, setting the start bit together with the write-enable and erase-select bits begins the row erase.
// - Two setup cycles pass after the start write before execution stalls.
// - Execution is halted for the erase time, typically 2 ms.
// - The stall is not sleep; clocks and peripherals keep running.
// - Execution resumes at the third instruction after the control write.
// - Data low byte is read/write, unknown at power-up, kept across resets.
// - Data high holds six upper word bits; its top two bits read zero.
// - Address low byte is read/write and cleared by reset.
// - Address high holds seven upper address bits, cleared by reset.
// - Top bit of the address high register always reads as one.
module flash_row_erase_control
  import flash_erase_pkg::*;
#(
  parameter int unsigned ERASE_COUNT = ERASE_CYCLES
)(
  input  wire logic                        aclk,        // 250 MHz clock
  input  wire logic                        aresetn,     // Synchronous reset, active low
  input  wire logic                        awvalid,     // Write address valid
  output      logic                        awready,     // Write address ready
  input  wire logic [7:0]                  awaddr,      // Write byte address
  input  wire logic                        wvalid,      // Write data valid
  output      logic                        wready,      // Write data ready
  input  wire logic [31:0]                 wdata,       // Write data
  input  wire logic [3:0]                  wstrb,       // Write byte strobes
  output      logic                        bvalid,      // Write response valid
  input  wire logic                        bready,      // Write response ready
  output      logic [1:0]                  bresp,       // Write response
  input  wire logic                        arvalid,     // Read address valid
  output      logic                        arready,     // Read address ready
  input  wire logic [7:0]                  araddr,      // Read byte address
  output      logic                        rvalid,      // Read data valid
  input  wire logic                        rready,      // Read data ready
  output      logic [31:0]                 rdata,       // Read data
  output      logic [1:0]                  rresp,       // Read response
  input  wire logic [ADDR_W-1:0]           cpu_pc,      // Address of the current write
  output      logic                        cpu_stall,   // Halts instruction execution
  output      flash_erase_pkg::flash_cmd_t flash_cmd,   // Erase command to the array
  output      flash_erase_pkg::core_resume_t core_resume // Resume pulse and target
);
  import flash_erase_pkg::*;

  typedef struct packed {
    phase_t             phase;
    logic [COUNT_W-1:0] count;
    unlock_t            unlock;
    logic [7:0]         data_low;
    logic [5:0]         data_high;
    logic [ADDR_W-1:0]  addr;
    logic               erase_sel;
    logic               program_write_enable;
    logic               cfg_sel;
    logic               start;
    logic               refused;
    logic               stall;
    flash_cmd_t         cmd;
    core_resume_t       res;
    logic               aw_held;
    logic [7:0]         aw_addr;
    logic               w_held;
    logic [7:0]         w_data;
    logic               w_lane0;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [7:0]         rd_addr;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_DATA_LOW) || (a == OFS_DATA_HIGH) || (a == OFS_ADDR_LOW) ||
             (a == OFS_ADDR_HIGH) || (a == OFS_CONTROL) || (a == OFS_UNLOCK);
  endfunction : mapped

  // Whole-row address: low word bits inside the row are forced to zero
  function automatic logic [ADDR_W-1:0] row_of(input logic [ADDR_W-1:0] a);
    row_of = {a[ADDR_W-1:ROW_WORDS_LOG2], {ROW_WORDS_LOG2{1'b0}}};
  endfunction : row_of

  function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a);
    read_reg = 32'h0000_0000;
    case (a)
      OFS_DATA_LOW:  read_reg[7:0] = s.data_low;
      OFS_DATA_HIGH: read_reg[5:0] = s.data_high;
      OFS_ADDR_LOW:  read_reg[7:0] = s.addr[7:0];
      OFS_ADDR_HIGH: read_reg[7:0] = {1'b1, s.addr[ADDR_W-1:8]};
      OFS_CONTROL:
      begin
        read_reg[BIT_START]     = s.start;
        read_reg[BIT_PROGRAM_WRITE_ENABLE]      = s.program_write_enable;
        read_reg[BIT_REFUSED]   = s.refused;
        read_reg[BIT_ERASE_SEL] = s.erase_sel;
        read_reg[BIT_CFG_SEL]   = s.cfg_sel;
      end
      default:       read_reg = 32'h0000_0000;
    endcase
  endfunction : read_reg

  // Reset clears control state; the data holding bytes keep their value
  function automatic state_t reset_of(input state_t s);
    reset_of           = '0;
    reset_of.phase     = PH_IDLE;
    reset_of.unlock    = UL_IDLE;
    reset_of.data_low  = s.data_low;
    reset_of.data_high = s.data_high;
  endfunction : reset_of

  always_comb
  begin
    logic do_write;
    logic [7:0] v;
    do_write = 1'b0;
    v        = 8'h00;
    next_st  = st;
    next_st.res.resume = 1'b0;

    // Write channel capture; address and data may arrive in either order
    if (awvalid && st.awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
      next_st.awready = 1'b0;
    end
    if (wvalid && st.wready)
    begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = wdata[7:0];
      next_st.w_lane0 = wstrb[0];
      next_st.wready  = 1'b0;
    end
    if (st.bvalid && bready)
    begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    if (st.aw_held && st.w_held && !st.bvalid)
    begin
      do_write        = st.w_lane0 && mapped(st.aw_addr);
      v               = st.w_data;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end

    if (do_write)
    begin
      // Any mapped write with byte lane 0 other than the next unlock step breaks the sequence
      next_st.unlock = UL_IDLE;
      case (st.aw_addr)
        OFS_DATA_LOW:  next_st.data_low  = v;
        OFS_DATA_HIGH: next_st.data_high = v[5:0];
        OFS_ADDR_LOW:  next_st.addr[7:0] = v;
        OFS_ADDR_HIGH: next_st.addr[ADDR_W-1:8] = v[6:0];
        OFS_UNLOCK:
        begin
          if (v == UNLOCK_FIRST)
            next_st.unlock = UL_GOT_FIRST;
          else if (v == UNLOCK_SECOND && st.unlock == UL_GOT_FIRST)
            next_st.unlock = UL_OPEN;
        end
        OFS_CONTROL:
        begin
          // Mode bits are frozen while an erase is under way
          if (st.phase == PH_IDLE)
          begin
            next_st.program_write_enable      = v[BIT_PROGRAM_WRITE_ENABLE];
            next_st.erase_sel = v[BIT_ERASE_SEL];
            next_st.cfg_sel   = v[BIT_CFG_SEL];
            if (!v[BIT_REFUSED])
              next_st.refused = 1'b0;
          end
          if (v[BIT_START] && st.phase == PH_IDLE)
          begin
            if (st.unlock == UL_OPEN && v[BIT_PROGRAM_WRITE_ENABLE] && v[BIT_ERASE_SEL])
            begin
              next_st.start  = 1'b1;
              next_st.phase  = PH_SETUP;
              next_st.count  = COUNT_W'(SETUP_CYCLES - 1);
              next_st.res.resume_pc = ADDR_W'(cpu_pc + ADDR_W'(RESUME_OFFSET));
            end
            else
            begin
              next_st.refused = 1'b1;
            end
          end
        end
        default: next_st.unlock = UL_IDLE;
      endcase
    end

    // Read channel: one read at a time, answered the cycle after acceptance
    if (st.rvalid && rready)
    begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
    if (arvalid && st.arready)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rd_addr = araddr;
      next_st.rdata   = read_reg(st, araddr);
      next_st.rresp   = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Erase sequencer; clocks stay running, only the core is held
    case (st.phase)
      PH_SETUP:
      begin
        if (st.count == '0)
        begin
          next_st.phase        = PH_ERASE;
          next_st.count        = COUNT_W'(ERASE_COUNT - 1);
          next_st.stall        = 1'b1;
          next_st.cmd.erase_on = 1'b1;
          next_st.cmd.row_addr = row_of(st.addr);
          next_st.cmd.config_space = st.cfg_sel;
        end
        else
          next_st.count = st.count - COUNT_W'(1);
      end
      PH_ERASE:
      begin
        if (st.count == '0)
        begin
          next_st.phase        = PH_IDLE;
          next_st.stall        = 1'b0;
          next_st.start        = 1'b0;
          next_st.cmd.erase_on = 1'b0;
          next_st.res.resume   = 1'b1;
        end
        else
          next_st.count = st.count - COUNT_W'(1);
      end
      PH_IDLE: ;
      default: next_st.phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st         <= reset_of(st);
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign awready     = st.awready;
  assign wready      = st.wready;
  assign bvalid      = st.bvalid;
  assign bresp       = st.bresp;
  assign arready     = st.arready;
  assign rvalid      = st.rvalid;
  assign rdata       = st.rdata;
  assign rresp       = st.rresp;
  assign cpu_stall   = st.stall;
  assign flash_cmd   = st.cmd;
  assign core_resume = st.res;

  // Checking helpers: length of the current stall, cleared when it ends
  logic [COUNT_W-1:0] stall_len;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stall_len <= '0;
    else if (st.stall)
      stall_len <= stall_len + COUNT_W'(1);
    else
      stall_len <= '0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence setup_two_s;
    !cpu_stall ##1 !cpu_stall ##1 cpu_stall;
  endsequence

  setup_delay_a: assert property ($rose(st.phase == PH_SETUP) |-> setup_two_s)
    else $error("stall did not follow two setup cycles");
  unlock_gate_a: assert property ($rose(st.phase == PH_SETUP) |->
      $past(st.unlock) == UL_OPEN)
    else $error("erase started without a fresh unlock");
  stall_len_a: assert property ($fell(cpu_stall) |->
      $past(stall_len) == COUNT_W'(ERASE_COUNT - 1))
    else $error("stall length differs from erase time");
  stall_cover_a: assert property (flash_cmd.erase_on |-> cpu_stall)
    else $error("erase active without stall");
  row_whole_a: assert property (flash_cmd.erase_on |->
      flash_cmd.row_addr[ROW_WORDS_LOG2-1:0] == '0)
    else $error("erase row address not row aligned");
  row_match_a: assert property ($rose(flash_cmd.erase_on) |->
      flash_cmd.row_addr == row_of(st.addr))
    else $error("erased row does not contain loaded address");
  resume_pulse_a: assert property ($fell(cpu_stall) |->
      core_resume.resume ##1 !core_resume.resume)
    else $error("resume pulse missing after erase");
  addr_top_a: assert property (rvalid && st.rd_addr == OFS_ADDR_HIGH |-> rdata[7:0]
      == {1'b1, st.addr[ADDR_W-1:8]})
    else $error("address high top bit not read as one");
  data_top_a: assert property (rvalid && st.rd_addr == OFS_DATA_HIGH |->
      rdata[31:6] == '0)
    else $error("data high upper bits not zero");

endmodule : flash_row_erase_control

// ### verif/core_model.sv
// Purpose: Processor core model that halts on stall and records the resume event.
// Assumes: One instruction per clock; the bench sets the pc of the control write.
// Notes:   The core counts its own halted cycles, so the bench never guesses them.
`timescale 1ns/1ps
module core_model
  import flash_erase_pkg::*;
(
  input  wire logic                          aclk,        // Clock
  input  wire logic                          aresetn,     // Synchronous reset, active low
  input  wire logic                          cpu_stall,   // Halt request
  input  wire flash_erase_pkg::core_resume_t core_resume, // Resume pulse and target
  input  wire logic [ADDR_W-1:0]             start_pc,    // Pc of the control write
  output      logic [ADDR_W-1:0]             cpu_pc,      // Pc shown to the controller
  output      int                            stall_len,   // Cycles spent halted
  output      logic [ADDR_W-1:0]             resume_pc,   // Where execution restarts
  output      logic                          resumed      // Resume pulse seen
);
  // Setup slots hold no-operation instructions, so the pc of the write stays put
  assign cpu_pc = start_pc;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stall_len <= 0;
      resumed   <= 1'b0;
      resume_pc <= '0;
    end
    else if (cpu_stall)
      stall_len <= stall_len + 1;
    else if (core_resume.resume)
    begin
      resumed   <= 1'b1;
      resume_pc <= core_resume.resume_pc;
    end
  end
endmodule : core_model

// ### verif/flash_row_erase_control_bench.sv
// Purpose: Self-checking bench for the flash row erase controller.
// Assumes: Erase count shortened to ERASE_N cycles.
// Notes:   Bus tasks release nothing before the handshake edge.
`timescale 1ns/1ps
module flash_row_erase_control_bench;
  import flash_erase_pkg::*;
  localparam int ERASE_N = 20;
  logic              aclk     = 1'b0;
  logic              aresetn  = 1'b0;
  logic              awvalid  = 1'b0;
  logic              wvalid   = 1'b0;
  logic              bready   = 1'b0;
  logic              arvalid  = 1'b0;
  logic              rready   = 1'b0;
  logic [7:0]        awaddr   = 8'h00;
  logic [7:0]        araddr   = 8'h00;
  logic [31:0]       wdata    = 32'h0;
  logic [3:0]        wstrb    = 4'h0;
  logic [ADDR_W-1:0] start_pc = 15'h0123;
  logic              awready, wready, bvalid, arready, rvalid, cpu_stall, resumed;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [ADDR_W-1:0] cpu_pc, resume_pc;
  flash_cmd_t        flash_cmd;
  core_resume_t      core_resume;
  int                stall_len;
  int                failures  = 0;
  int                cmp_count = 0;

  always #2 aclk = ~aclk;

  flash_row_erase_control #(.ERASE_COUNT(ERASE_N)) flash_row_erase_control_inst (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .cpu_pc(cpu_pc),
    .cpu_stall(cpu_stall), .flash_cmd(flash_cmd), .core_resume(core_resume));

  core_model core_model_inst (
    .aclk(aclk), .aresetn(aresetn), .cpu_stall(cpu_stall), .core_resume(core_resume),
    .start_pc(start_pc), .cpu_pc(cpu_pc), .stall_len(stall_len), .resume_pc(resume_pc),
    .resumed(resumed));

  task automatic final_report;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic timeout(input string what);
    failures++;
    $display("unexpected at %0t: no answer on %s", $time, what);
    final_report();
  endtask : timeout

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // Starts one edge late so bready is never driven twice in one time step
  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data,
                           output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awaddr  <= addr;
    wdata   <= {24'h0, data};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        resp = bresp;
        return;
      end
    end
    timeout("write");
  endtask : axi_write

  task automatic axi_read(input logic [7:0] addr, output logic [7:0] data,
                          output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        data = rdata[7:0];
        resp = rresp;
        return;
      end
    end
    timeout("read");
  endtask : axi_read

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [1:0] resp;
    axi_write(addr, data, resp);
    check_val({30'h0, resp}, {30'h0, RESP_OKAY}, "write response");
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] resp;
    axi_read(addr, d, resp);
    check_val({22'h0, resp, d}, {22'h0, RESP_OKAY, exp}, "read");
  endtask : rd

  initial
  begin
    logic [7:0] d;
    logic [1:0] resp;
    int         n;
    do_reset();
    rd(OFS_ADDR_LOW, 8'h00);
    rd(OFS_ADDR_HIGH, 8'h80);
    rd(OFS_CONTROL, 8'h00);
    wr(OFS_DATA_LOW, 8'ha5);
    wr(OFS_DATA_HIGH, 8'hff);
    wr(OFS_ADDR_LOW, 8'h37);
    wr(OFS_ADDR_HIGH, 8'h7f);
    rd(OFS_DATA_HIGH, 8'h3f);
    rd(OFS_ADDR_HIGH, 8'hff);
    do_reset();
    rd(OFS_DATA_LOW, 8'ha5);
    rd(OFS_ADDR_LOW, 8'h00);
    rd(OFS_ADDR_HIGH, 8'h80);
    axi_read(8'h18, d, resp);
    check_val({22'h0, resp, d}, {22'h0, RESP_SLVERR, 8'h00}, "unmapped read");
    axi_write(8'h1c, 8'h01, resp);
    check_val({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    // Starts without unlock, with reversed unlock, broken unlock, missing enables
    for (n = 0; n < 4; n++)
    begin
      if (n == 1)
        wr(OFS_UNLOCK, UNLOCK_SECOND);
      if (n >= 1)
        wr(OFS_UNLOCK, UNLOCK_FIRST);
      if (n >= 2)
        wr(OFS_UNLOCK, UNLOCK_SECOND);
      if (n == 2)
        wr(OFS_ADDR_LOW, 8'h37);
      wr(OFS_CONTROL, (n == 3) ? 8'h01 : 8'h15);
      rd(OFS_CONTROL, (n == 3) ? 8'h08 : 8'h1c);
      check_val(32'(stall_len), 32'h0, "refused start");
      wr(OFS_CONTROL, 8'h00);
    end
    wr(OFS_ADDR_HIGH, 8'h12);
    wr(OFS_ADDR_LOW, 8'h37);
    wr(OFS_CONTROL, 8'h54);
    rd(OFS_CONTROL, 8'h54);
    wr(OFS_CONTROL, 8'h14);
    wr(OFS_UNLOCK, UNLOCK_FIRST);
    wr(OFS_UNLOCK, UNLOCK_SECOND);
    wr(OFS_CONTROL, 8'h15);
    // Sample mid-cycle so the stall launched at the edge has settled
    @(negedge aclk);
    check_val({31'h0, cpu_stall}, 32'h0, "setup slot");
    @(negedge aclk);
    check_val({31'h0, cpu_stall}, 32'h1, "stall");
    check_val({15'h0, flash_cmd}, {15'h0, 1'b1, 1'b0, 15'h1220}, "row command");
    rd(OFS_CONTROL, 8'h15);
    // Mode bits stay frozen while the erase runs
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_CONTROL, 8'h15);
    for (n = 0; n < 100 && resumed !== 1'b1; n++)
      @(posedge aclk);
    if (n == 100)
      timeout("resume");
    check_val(32'(stall_len), 32'(ERASE_N), "stall length");
    check_val({17'h0, resume_pc}, {17'h0, 15'h0126}, "resume pc");
    check_val({31'h0, flash_cmd.erase_on}, 32'h0, "erase end");
    rd(OFS_CONTROL, 8'h14);
    final_report();
  end
endmodule : flash_row_erase_control_bench
